// ---- hw/carl_consts.svh ----
// Purpose: constants for the command/address reference level mode register
// Assumes: six-bit mode register address, eight operand bits
// Notes:   definitions only
`ifndef CARL_CONSTS_SVH
`define CARL_CONSTS_SVH

`define CARL_ADDR_W          6
`define CARL_DATA_W          8
`define CARL_ADDR_LEVEL      6'h0C
`define CARL_ADDR_FSP_CTRL   6'h0D
`define CARL_LEVEL_LSB       0
`define CARL_LEVEL_MSB       5
`define CARL_RANGE_BIT       6
`define CARL_ACCESS_SEL_BIT  6
`define CARL_OPERATE_SEL_BIT 7
`define CARL_LEVEL_MAX       6'h32
`define CARL_RST_LEVEL       6'h0D
`define CARL_RST_RANGE       1'h1
`define CARL_RST_SEL         1'h0

`endif

// ---- hw/carl_pkg.sv ----
// Purpose: types for the command/address reference level mode register
// Assumes: constants come from carl_consts.svh
// Notes:   one set-point copy is range bit plus level code
`include "carl_consts.svh"

package carl_pkg;

	typedef struct packed {
		logic       range;
		logic [5:0] level;
	} carl_copy_t;

	typedef struct packed {
		carl_copy_t copy0;
		carl_copy_t copy1;
		logic       access_sel;
		logic       operate_sel;
		logic       rd_valid;
		logic [7:0] rd_data;
	} carl_state_t;

endpackage : carl_pkg

// ---- hw/carl_mode_reg.sv ----
// Purpose: two-copy command/address reference level mode register
// Assumes: write/read commands are decoded one cycle strobes, synchronous to clk
// Notes:   only the two select bits of the set-point control register live here
`timescale 1ns/1ns
`include "carl_consts.svh"

// Behaviour
// RULE1 - register decoded at mode register address 0CH for writes and reads
// RULE2 - six-bit level code in bits 5:0; codes above 110010B are reserved
// RULE3 - bit 6 selects between two reference ranges; writing it switches range
// RULE4 - controller writes range together with level code every time
// RULE5 - read drives all eight bits; reserved bit and unused lines read zero
// RULE6 - level write goes to copy 0 or copy 1 per access select
// RULE7 - two copies per bit; writes reach only the access-selected copy
// RULE8 - reads return the access-selected copy, not necessarily the operating one
// RULE9 - operation uses only the operate-selected copy; the other is ignored
// RULE10 - range value persists until overwritten or reset
// RULE11 - access select is bit 6 of set-point control, default set point 0
// RULE12 - operate select is bit 7 of set-point control, default set point 0
// RULE13 - reset loads both copies with default level code and default range
module carl_mode_reg (
	// clock, reset, enable
	input  wire logic       clk,
	input  wire logic       rst_n,
	input  wire logic       clk_en,
	// mode register command port
	input  wire logic       mrw_valid,
	input  wire logic       mrr_valid,
	input  wire logic [5:0] mode_reg_address,
	input  wire logic [7:0] operand_bits,
	// read data
	output logic            rd_valid,
	output logic [7:0]      rd_data,
	// operating reference setting
	output logic [5:0]      ca_reference_level,
	output logic            ca_reference_range,
	output logic            level_code_reserved,
	output logic            setpoint_access_select,
	output logic            setpoint_operate_select
);

	// registered state and its next value
	carl_pkg::carl_state_t s_q;
	carl_pkg::carl_state_t s_d;

	// set-point copies as seen through the write path and the two selects
	carl_pkg::carl_copy_t  wr_copy;
	carl_pkg::carl_copy_t  acc_copy;
	carl_pkg::carl_copy_t  op_copy;

	// address decode
	logic                  hit_level;
	logic                  hit_ctrl;

	// command strobes after decode
	logic                  wr_level;
	logic                  wr_ctrl;
	logic                  rd_level;

	// per-copy write enables
	logic                  wr_copy0;
	logic                  wr_copy1;

	// select bits carried by a control write
	logic                  new_access_sel;
	logic                  new_operate_sel;

	// read answer built from the access-selected copy
	logic [7:0]            rd_word;

	// the reserved top bit holds no state, so it is rebuilt as zero on every read
	function automatic logic [7:0] carl_pack(input carl_pkg::carl_copy_t cp);
		logic [7:0] w;
		w                                  = 8'h00;
		w[`CARL_RANGE_BIT]                 = cp.range;
		w[`CARL_LEVEL_MSB:`CARL_LEVEL_LSB] = cp.level;
		return w;
	endfunction : carl_pack

	assign hit_level = (mode_reg_address == `CARL_ADDR_LEVEL);    // see RULE1
	assign hit_ctrl  = (mode_reg_address == `CARL_ADDR_FSP_CTRL);

	// commands to any other address fall through untouched
	assign wr_level = mrw_valid && hit_level;                      // see RULE1
	assign wr_ctrl  = mrw_valid && hit_ctrl;
	assign rd_level = mrr_valid && hit_level;                      // see RULE1

	// level and range always taken from the same write, never merged
	assign wr_copy.range = operand_bits[`CARL_RANGE_BIT];          // see RULE3, see RULE4
	assign wr_copy.level = operand_bits[`CARL_LEVEL_MSB:`CARL_LEVEL_LSB];  // see RULE2

	// the select in force at the taking edge decides; a control write in the
	// same cycle only steers the commands that follow it
	assign wr_copy0 = wr_level && !s_q.access_sel;                 // see RULE6, see RULE7
	assign wr_copy1 = wr_level && s_q.access_sel;                  // see RULE6, see RULE7

	// the other control bits belong elsewhere and are dropped here
	assign new_access_sel  = operand_bits[`CARL_ACCESS_SEL_BIT];   // see RULE11
	assign new_operate_sel = operand_bits[`CARL_OPERATE_SEL_BIT];  // see RULE12

	always_comb begin
		case (s_q.access_sel)
			1'h0: begin
				acc_copy = s_q.copy0;                              // see RULE8
			end
			1'h1: begin
				acc_copy = s_q.copy1;                              // see RULE8
			end
			default: begin
				acc_copy = s_q.copy0;
			end
		endcase
	end

	// the inactive copy never reaches ca_reference_level or ca_reference_range, so it may be rewritten freely
	always_comb begin
		case (s_q.operate_sel)
			1'h0: begin
				op_copy = s_q.copy0;                               // see RULE9
			end
			1'h1: begin
				op_copy = s_q.copy1;                               // see RULE9
			end
			default: begin
				op_copy = s_q.copy0;
			end
		endcase
	end

	assign rd_word = carl_pack(acc_copy);                          // see RULE5, see RULE8

	always_comb begin
		s_d          = s_q;
		s_d.rd_valid = 1'h0;
		// a write never touches the copy that is not access-selected
		if (wr_copy0) begin
			s_d.copy0 = wr_copy;                                   // see RULE10
		end
		if (wr_copy1) begin
			s_d.copy1 = wr_copy;                                   // see RULE10
		end
		if (wr_ctrl) begin
			s_d.access_sel  = new_access_sel;                      // see RULE11
			s_d.operate_sel = new_operate_sel;                     // see RULE12
		end
		// rd_data keeps the last answer so a late sampler still sees it
		if (rd_level) begin
			s_d.rd_valid = 1'h1;                                   // see RULE5
			s_d.rd_data  = rd_word;                                // see RULE5, see RULE8
		end
	end

	// low clk_en freezes everything, a pending read answer included
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			// both copies start from the same defined setting
			s_q.copy0.range <= `CARL_RST_RANGE;                    // see RULE13
			s_q.copy0.level <= `CARL_RST_LEVEL;                    // see RULE13
			s_q.copy1.range <= `CARL_RST_RANGE;                    // see RULE13
			s_q.copy1.level <= `CARL_RST_LEVEL;                    // see RULE13
			s_q.access_sel  <= `CARL_RST_SEL;                      // see RULE11
			s_q.operate_sel <= `CARL_RST_SEL;                      // see RULE12
			s_q.rd_valid    <= 1'h0;
			s_q.rd_data     <= 8'h00;
		end else if (clk_en) begin
			s_q <= s_d;
		end
	end

	// read port
	assign rd_valid                = s_q.rd_valid;
	assign rd_data                 = s_q.rd_data;

	// operating setting
	assign ca_reference_level      = op_copy.level;               // see RULE9
	assign ca_reference_range      = op_copy.range;               // see RULE9

	// reserved codes are stored as written; flagged while in the operate-selected copy so the analogue side can hold off
	always_comb begin
		if (op_copy.level > `CARL_LEVEL_MAX) begin                 // see RULE2
			level_code_reserved = 1'h1;
		end else begin
			level_code_reserved = 1'h0;
		end
	end

	// selects
	assign setpoint_access_select  = s_q.access_sel;
	assign setpoint_operate_select = s_q.operate_sel;

endmodule : carl_mode_reg

// ---- verification/carl_sva.sv ----
// Purpose: port checks
// Assumes: one clock
// Notes: bound below
`timescale 1ns/1ns
module carl_chk(input logic clk,rst_n,clk_en,mrw_valid,mrr_valid,rd_valid,ca_reference_range,
	setpoint_access_select,setpoint_operate_select,level_code_reserved,
	input logic [5:0] mode_reg_address,
	input logic [5:0] ca_reference_level,input logic [7:0] operand_bits,rd_data);
	default clocking @(posedge clk);endclocking
	default disable iff(!rst_n);
	wire m=clk_en&&mode_reg_address==6'h0C,r=m&&mrr_valid,w=m&&mrw_valid;
	wire c=clk_en&&mrw_valid&&mode_reg_address==6'h0D;
	wire a=setpoint_access_select,f=setpoint_operate_select,s=a==f;
	wire [6:0] v={ca_reference_range,ca_reference_level};
	property p_rd;r|=>rd_valid;endproperty
	a_rd:assert property(p_rd)else $error("read");
	property p_no;!r&&clk_en|=>!rd_valid;endproperty
	a_no:assert property(p_no)else $error("stray");
	property p_b7;rd_valid|->!rd_data[7];endproperty
	a_b7:assert property(p_b7)else $error("bit7");
	property p_wr;w&&s|=>v==$past(operand_bits[6:0]);endproperty
	a_wr:assert property(p_wr)else $error("write");
	property p_in;w&&!s|=>$stable(v);endproperty
	a_in:assert property(p_in)else $error("idle");
	property p_kp;!w&&!c|=>$stable(v);endproperty
	a_kp:assert property(p_kp)else $error("drift");
	property p_bk;w##1 r&&$stable(a)|=>rd_data[6:0]==$past(operand_bits[6:0],2);endproperty
	a_bk:assert property(p_bk)else $error("back");
	property p_sl;c|=>{f,a}==$past(operand_bits[7:6]);endproperty
	a_sl:assert property(p_sl)else $error("sel");
	property p_rs;level_code_reserved==(ca_reference_level>6'h32);endproperty
	a_rs:assert property(p_rs)else $error("reserved");
	cover property(r);
	cover property(w&&!s);
	cover property(c);
endmodule:carl_chk
bind carl_mode_reg carl_chk chk_u(.*);

// ---- verification/carl_ctl.sv ----
// Purpose: controller model
// Assumes: edge aligned calls
// Notes: idle data inverted
`timescale 1ns/1ns
module carl_ctl(input logic clk,output logic mrw_valid=0,mrr_valid=0,
	output logic [5:0] mode_reg_address=0,output logic [7:0] operand_bits=0);
	task cmd(logic w,logic [5:0] a,logic [7:0] d);
		{mrw_valid,mrr_valid,mode_reg_address,operand_bits}={w,!w,a,d};
		@(posedge clk)#1;
	endtask:cmd
	task idle;
		{mrw_valid,mrr_valid,operand_bits}={2'h0,~operand_bits};
		repeat(2)@(posedge clk)#1;
	endtask:idle
endmodule:carl_ctl

// ---- verification/testbench.sv ----
// Purpose: bench
// Assumes: model drives
// Notes: reads queued
`timescale 1ns/1ns
module testbench;
	logic clk=0,rst_n=0,clk_en=1,mrw_valid,mrr_valid,rd_valid,ca_reference_range;
	logic level_code_reserved,setpoint_access_select,setpoint_operate_select;
	logic [5:0] mode_reg_address,ca_reference_level;
	logic [7:0] operand_bits,rd_data,v,c[2]='{8'h4D,8'h4D},q[$];
	int n_fail=0,n_tests=0;
	carl_mode_reg dut_u(.*);
	carl_ctl ctl_u(.*);
	initial forever #10 clk=~clk;
	task chk(string n,logic [7:0] s,e);
		n_tests++;
		if(s!==e)begin n_fail++;$display("ERROR %s exp %h seen %h",n,e,s);end
	endtask:chk
	task final_report;
		$display("%0d checks %0d errors",n_tests,n_fail);
		if(n_fail==0&&n_tests>0)$display("NO MISMATCHES");else $display("MISMATCHES SEEN");
		$finish;
	endtask:final_report
	always @(negedge clk)if(rd_valid===1)chk("rd",rd_data,q.size()?q.pop_front():8'hFF);
	initial begin #9000;n_fail++;final_report;end
	initial begin
		void'($urandom(32'hA8A9));repeat(8)@(posedge clk);#1 rst_n=1;
		for(int i=0;i<9;i++)begin
			// pass 0 sees reset copies; later passes walk every select pair
			if(i>0)begin v=$urandom;c[i[0]]=v&8'h7F;ctl_u.cmd(1,6'h0D,{i[1:0],6'h2A});end
			if(i>0)ctl_u.cmd(1,6'h0C,v);
			q.push_back(c[i[0]]);ctl_u.cmd(0,6'h0C,v);ctl_u.cmd(0,6'h0B,v);ctl_u.idle;
			chk("op",{1'b0,ca_reference_range,ca_reference_level},c[i[1]]);
			chk("sel",{setpoint_operate_select,setpoint_access_select},{6'h0,i[1:0]});
			chk("rsv",level_code_reserved,c[i[1]][5:0]>6'h32);
		end
		// commands while frozen must leave no trace
		clk_en=0;ctl_u.cmd(1,6'h0C,8'h00);ctl_u.cmd(0,6'h0C,8'h00);ctl_u.idle;clk_en=1;
		chk("frz",{1'b0,ca_reference_range,ca_reference_level},c[0]);
		rst_n=0;@(posedge clk)#1 rst_n=1;repeat(2)@(posedge clk);#1;
		chk("rst",{1'b0,ca_reference_range,ca_reference_level},8'h4D);
		chk("rsel",{setpoint_operate_select,setpoint_access_select},8'h00);
		q.push_back(8'h4D);ctl_u.cmd(0,6'h0C,8'h00);ctl_u.idle;
		chk("pend",q.size(),8'h00);
		final_report;
	end
endmodule:testbench
